// ---- opbr_defines.vh ----
// Constants for the parameter fuse bank reader
`ifndef OPBR_DEFINES_VH
`define OPBR_DEFINES_VH
// Geometry
`define OPBR_BANKS          6
`define OPBR_BANK_BITS      128
`define OPBR_FUSE_BITS      768
`define OPBR_FIXED_BITS     108
// Bank layout
`define OPBR_USED_BIT       0
`define OPBR_INVALID_BIT    1
`define OPBR_MAC_VALID_BIT  2
`define OPBR_MAC_LSB        3
`define OPBR_MAC_MSB        50
`define OPBR_ADC_VALID_BIT  51
`define OPBR_ADC_LSB        52
`define OPBR_ADC_MSB        59
`define OPBR_XO_VALID_BIT   60
`define OPBR_XO_LSB         61
`define OPBR_XO_MSB         75
`define OPBR_IQG_VALID_BIT  76
`define OPBR_IQG_LSB        77
`define OPBR_IQG_MSB        85
`define OPBR_IQP_VALID_BIT  86
`define OPBR_IQP_LSB        87
`define OPBR_IQP_MSB        95
// Register byte offsets
`define OPBR_CTRL_OFS       8'h00
`define OPBR_STATUS_OFS     8'h04
`define OPBR_PADDR_OFS      8'h08
`define OPBR_PDATA_OFS      8'h0C
`define OPBR_RAW_OFS        8'h10
`define OPBR_MACLO_OFS      8'h14
`define OPBR_MACHI_OFS      8'h18
`define OPBR_RADLO_OFS      8'h1C
`define OPBR_RADHI_OFS      8'h20
`define OPBR_CAL_OFS        8'h24
`define OPBR_IQ_OFS         8'h28
// Control bits
`define OPBR_CTRL_RELOAD    0
`define OPBR_CTRL_PROG      1
// Reset values
`define OPBR_PADDR_RST      32'h00000000
`define OPBR_PDATA_RST      32'h00000000
// Timing: fuse program pulse
`define OPBR_CLK_PERIOD_NS  10
`define OPBR_PROG_TIME_NS   10000
`define OPBR_PROG_CYCLES    ((`OPBR_PROG_TIME_NS + `OPBR_CLK_PERIOD_NS - 1) / `OPBR_CLK_PERIOD_NS)
`endif

// ---- opbr_fuse_array.v ----
// Fuse storage: six independent banks, bits only ever blow from 0 to 1
`timescale 1ns/10ps
`default_nettype none
`include "opbr_defines.vh"
module opbr_fuse_array #(
  parameter [47:0] SHIP_MAC = 48'h000000000001,
  parameter [14:0] SHIP_XO  = 15'h0000,
  parameter [8:0]  SHIP_IQG = 9'h000,
  parameter [8:0]  SHIP_IQP = 9'h000
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         wr_en,
  input  wire [2:0]   wr_bank,
  input  wire [1:0]   wr_word,
  input  wire [31:0]  wr_data,
  output wire [767:0] fuse_flat
);
  genvar b;
  generate
    for (b = 0; b < `OPBR_BANKS; b = b + 1) begin : g_bank
      reg [127:0] bits;
      // Reset models power-up image; programming ORs one word into its own bank
      always @(posedge clk) begin
        if (rst) begin
          bits <= 128'h0;
          if (b == 3) begin
            bits[`OPBR_USED_BIT]                 <= 1'b1;
            bits[`OPBR_MAC_VALID_BIT]            <= 1'b1;
            bits[`OPBR_MAC_MSB:`OPBR_MAC_LSB]    <= SHIP_MAC;
            bits[`OPBR_XO_VALID_BIT]             <= 1'b1;
            bits[`OPBR_XO_MSB:`OPBR_XO_LSB]      <= SHIP_XO;
            bits[`OPBR_IQG_VALID_BIT]            <= 1'b1;
            bits[`OPBR_IQG_MSB:`OPBR_IQG_LSB]    <= SHIP_IQG;
            bits[`OPBR_IQP_VALID_BIT]            <= 1'b1;
            bits[`OPBR_IQP_MSB:`OPBR_IQP_LSB]    <= SHIP_IQP;
          end
        end else if (wr_en && wr_bank == b) begin
          bits[{wr_word, 5'h00} +: 32] <= bits[{wr_word, 5'h00} +: 32] | wr_data;
        end
      end
      assign fuse_flat[b*128 +: 128] = bits;
    end
  endgenerate
endmodule // opbr_fuse_array
`default_nettype wire

// ---- opbr_bank_pick.v ----
// Active bank choice: highest bank marked used and not invalidated
`timescale 1ns/10ps
`default_nettype none
`include "opbr_defines.vh"
module opbr_bank_pick (
  input  wire [767:0] fuse_flat,
  output reg  [2:0]   sel_idx,
  output reg          none_found,
  output reg  [127:0] sel_bank
);
  wire [5:0] qual;
  integer i;
  genvar b;
  generate
    for (b = 0; b < `OPBR_BANKS; b = b + 1) begin : g_qual
      // Bank qualifies when used and not invalid
      assign qual[b] = fuse_flat[b*128 + `OPBR_USED_BIT] & ~fuse_flat[b*128 + `OPBR_INVALID_BIT];
    end
  endgenerate
  // Later banks override earlier ones
  always @* begin
    sel_idx    = 3'h0;
    none_found = 1'b1;
    sel_bank   = 128'h0;
    for (i = 0; i < `OPBR_BANKS; i = i + 1) begin
      if (qual[i]) begin
        sel_idx    = i[2:0];
        none_found = 1'b0;
        sel_bank   = fuse_flat[i*128 +: 128];
      end
    end
  end
endmodule // opbr_bank_pick
`default_nettype wire

// ---- opbr_reader.v ----
// Parameter fuse bank reader with APB register access
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "opbr_defines.vh"
// Summary of operation
// - 768 fuse bits in six 128-bit banks, readable once reset completes
// - All banks share one layout: 108 fixed-purpose bits, 20 software bits
// - Each parameter field has a flag: 0 unusable, 1 valid
// - Any bank can be programmed on its own, allowing repeated updates
// - Bank 3 ships holding address, frequency offset and IQ trims
// - Radio address is the stored station address plus one
// - IQ trims load only when both IQ flags are 1, else ignored
module opbr_reader #(
  parameter [15:0] PROG_CYCLES = `OPBR_PROG_CYCLES,
  parameter [47:0] SHIP_MAC    = 48'h000000000001,
  parameter [14:0] SHIP_XO     = 15'h0000,
  parameter [8:0]  SHIP_IQG    = 9'h000,
  parameter [8:0]  SHIP_IQP    = 9'h000
) (
  input  wire        REF_CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         PARAM_READY,
  output reg         NO_PARAMS
);
  localparam [3:0] ST_BOOT = 4'b0001;
  localparam [3:0] ST_LOAD = 4'b0010;
  localparam [3:0] ST_IDLE = 4'b0100;
  localparam [3:0] ST_PROG = 4'b1000;

  // Sequencer, pulse timer and program target
  reg  [3:0]   state;
  reg  [3:0]   next_state;
  reg  [15:0]  prog_cnt;
  reg          prog_pend;
  reg          reload_pend;
  reg  [31:0]  prog_addr;
  reg  [31:0]  prog_data;
  reg          fuse_wr;
  reg  [2:0]   act_bank;
  // Captured parameters
  reg  [47:0]  mac;
  reg          mac_valid;
  reg  [47:0]  radio_addr;
  reg  [7:0]   adc_cal;
  reg          adc_valid;
  reg  [14:0]  xo_trim;
  reg          xo_valid;
  reg  [8:0]   iq_gain_trim;
  reg          iq_gain_valid;
  reg  [8:0]   iq_phase_trim;
  reg          iq_phase_valid;
  reg          iq_loaded;
  reg  [31:0]  rd_mux;
  reg          rd_err;
  reg  [31:0]  raw_word;
  reg  [2:0]   pulse_bank;
  reg  [1:0]   pulse_word;
  reg  [31:0]  pulse_data;
  // Bank choice and bus decode
  wire [767:0] fuse_flat;
  wire [2:0]   sel_idx;
  wire         none_found;
  wire [127:0] sel_bank;
  wire         setup_ph;
  wire         wr_take;
  wire         ctrl_wr;
  wire         take_prog;
  wire         take_reload;
  wire [2:0]   pa_bank;
  wire [1:0]   pa_word;
  wire [15:0]  pulse_len;
  wire         busy;
  wire [31:0]  status_word;

  // Bus phase decode
  assign setup_ph    = PSEL & ~PENABLE;
  assign wr_take     = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign ctrl_wr     = wr_take & (PADDR == `OPBR_CTRL_OFS);
  assign take_prog   = (state == ST_IDLE) & prog_pend;
  assign take_reload = (state == ST_IDLE) & ~prog_pend & reload_pend;
  assign pa_bank     = prog_addr[2:0];
  assign pa_word     = prog_addr[5:4];

  // A zero count would wrap and stretch the pulse to 65536 cycles
  assign pulse_len   = (PROG_CYCLES == 16'h0000) ? 16'h0001 : PROG_CYCLES;

  // Status word; busy covers a pending and a running program
  assign busy        = (state == ST_PROG) | prog_pend;
  assign status_word = {23'h0, iq_loaded, 1'b0, act_bank, 1'b0, busy, NO_PARAMS, PARAM_READY};

  // Fuse storage
  opbr_fuse_array #(
    .SHIP_MAC (SHIP_MAC),
    .SHIP_XO  (SHIP_XO),
    .SHIP_IQG (SHIP_IQG),
    .SHIP_IQP (SHIP_IQP)
  ) u_array (
    .clk       (REF_CLK),
    .rst       (RST),
    .wr_en     (fuse_wr),
    .wr_bank   (pulse_bank),
    .wr_word   (pulse_word),
    .wr_data   (pulse_data),
    .fuse_flat (fuse_flat)
  );

  // Active bank selection
  opbr_bank_pick u_pick (
    .fuse_flat  (fuse_flat),
    .sel_idx    (sel_idx),
    .none_found (none_found),
    .sel_bank   (sel_bank)
  );

  // Sequencer next state
  always @* begin
    case (state)
      ST_BOOT: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
      ST_IDLE: begin
        if (take_prog) begin
          next_state = ST_PROG;
        end else if (take_reload) begin
          next_state = ST_LOAD;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_PROG: next_state = (prog_cnt == 16'h0001) ? ST_IDLE : ST_PROG;
      default: next_state = ST_BOOT;
    endcase
  end

  // Sequencer state and program pulse timer
  always @(posedge REF_CLK) begin
    if (RST) begin
      state    <= ST_BOOT;
      prog_cnt <= 16'h0000;
      fuse_wr  <= 1'b0;
    end else begin
      state   <= next_state;
      fuse_wr <= (state == ST_PROG) && (prog_cnt == 16'h0001);
      if (take_prog) begin
        prog_cnt <= pulse_len;
      end else if (state == ST_PROG) begin
        prog_cnt <= prog_cnt - 16'h0001;
      end
    end
  end

  // Pending requests; a new request beats the take in the same cycle
  always @(posedge REF_CLK) begin
    if (RST) begin
      prog_pend   <= 1'b0;
      reload_pend <= 1'b0;
    end else begin
      prog_pend   <= (ctrl_wr & PWDATA[`OPBR_CTRL_PROG]) | (prog_pend & ~take_prog);
      reload_pend <= (ctrl_wr & PWDATA[`OPBR_CTRL_RELOAD]) | (reload_pend & ~take_reload);
    end
  end

  // Program address and data registers
  always @(posedge REF_CLK) begin
    if (RST) begin
      prog_addr <= `OPBR_PADDR_RST;
      prog_data <= `OPBR_PDATA_RST;
    end else if (wr_take) begin
      if (PADDR == `OPBR_PADDR_OFS) begin
        prog_addr <= {26'h0, PWDATA[5:4], 1'b0, PWDATA[2:0]};
      end
      if (PADDR == `OPBR_PDATA_OFS) begin
        prog_data <= PWDATA;
      end
    end
  end

  // Program target frozen as the pulse starts, so bus writes cannot retarget a running pulse
  always @(posedge REF_CLK) begin
    if (RST) begin
      pulse_bank <= 3'h7;
      pulse_word <= 2'h0;
      pulse_data <= 32'h00000000;
    end else if (take_prog) begin
      pulse_bank <= pa_bank;
      pulse_word <= pa_word;
      pulse_data <= prog_data;
    end
  end

  // Load status from the active bank choice
  always @(posedge REF_CLK) begin
    if (RST) begin
      PARAM_READY <= 1'b0;
      NO_PARAMS   <= 1'b0;
      act_bank    <= 3'h0;
    end else if (state == ST_LOAD) begin
      PARAM_READY <= 1'b1;
      NO_PARAMS   <= none_found;
      act_bank    <= sel_idx;
    end
  end

  // Address and calibration fields; a clear flag forces its field to zero
  always @(posedge REF_CLK) begin
    if (RST) begin
      mac        <= 48'h0;
      mac_valid  <= 1'b0;
      radio_addr <= 48'h0;
      adc_cal    <= 8'h00;
      adc_valid  <= 1'b0;
      xo_trim    <= 15'h0000;
      xo_valid   <= 1'b0;
    end else if (state == ST_LOAD) begin
      // Layout is common to all banks
      mac_valid  <= sel_bank[`OPBR_MAC_VALID_BIT];
      mac        <= sel_bank[`OPBR_MAC_VALID_BIT] ? sel_bank[`OPBR_MAC_MSB:`OPBR_MAC_LSB] : 48'h0;
      radio_addr <= sel_bank[`OPBR_MAC_VALID_BIT] ? sel_bank[`OPBR_MAC_MSB:`OPBR_MAC_LSB] + 48'h1 : 48'h0;
      adc_valid  <= sel_bank[`OPBR_ADC_VALID_BIT];
      adc_cal    <= sel_bank[`OPBR_ADC_VALID_BIT] ? sel_bank[`OPBR_ADC_MSB:`OPBR_ADC_LSB] : 8'h00;
      xo_valid   <= sel_bank[`OPBR_XO_VALID_BIT];
      xo_trim    <= sel_bank[`OPBR_XO_VALID_BIT] ? sel_bank[`OPBR_XO_MSB:`OPBR_XO_LSB] : 15'h0000;
    end
  end

  // IQ trims: the pair is taken only as a whole, single flags still reported
  always @(posedge REF_CLK) begin
    if (RST) begin
      iq_gain_trim   <= 9'h000;
      iq_gain_valid  <= 1'b0;
      iq_phase_trim  <= 9'h000;
      iq_phase_valid <= 1'b0;
      iq_loaded      <= 1'b0;
    end else if (state == ST_LOAD) begin
      iq_gain_valid  <= sel_bank[`OPBR_IQG_VALID_BIT];
      iq_phase_valid <= sel_bank[`OPBR_IQP_VALID_BIT];
      if (sel_bank[`OPBR_IQG_VALID_BIT] & sel_bank[`OPBR_IQP_VALID_BIT]) begin
        iq_gain_trim  <= sel_bank[`OPBR_IQG_MSB:`OPBR_IQG_LSB];
        iq_phase_trim <= sel_bank[`OPBR_IQP_MSB:`OPBR_IQP_LSB];
        iq_loaded     <= 1'b1;
      end else begin
        iq_gain_trim  <= 9'h000;
        iq_phase_trim <= 9'h000;
        iq_loaded     <= 1'b0;
      end
    end
  end

  // Raw fuse word addressed by the program address
  always @* begin
    if (pa_bank < 3'h6) begin
      raw_word = fuse_flat[{pa_bank, pa_word, 5'h00} +: 32];
    end else begin
      raw_word = 32'h00000000;
    end
  end

  // Register read decode
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (PADDR)
      `OPBR_CTRL_OFS:   rd_mux = 32'h00000000;
      `OPBR_STATUS_OFS: rd_mux = status_word;
      `OPBR_PADDR_OFS:  rd_mux = prog_addr;
      `OPBR_PDATA_OFS:  rd_mux = prog_data;
      `OPBR_RAW_OFS:    rd_mux = raw_word;
      `OPBR_MACLO_OFS:  rd_mux = mac[31:0];
      `OPBR_MACHI_OFS:  rd_mux = {mac_valid, 15'h0, mac[47:32]};
      `OPBR_RADLO_OFS:  rd_mux = radio_addr[31:0];
      `OPBR_RADHI_OFS:  rd_mux = {mac_valid, 15'h0, radio_addr[47:32]};
      `OPBR_CAL_OFS:    rd_mux = {7'h0, xo_trim, xo_valid, adc_valid, adc_cal};
      `OPBR_IQ_OFS:     rd_mux = {12'h0, iq_phase_valid, iq_phase_trim, iq_gain_valid, iq_gain_trim};
      default:          rd_err = 1'b1;
    endcase
  end

  // APB answer: ready in the first access cycle
  always @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (setup_ph) begin
      PRDATA  <= PWRITE ? 32'h00000000 : rd_mux;
      PREADY  <= 1'b1;
      PSLVERR <= rd_err;
    end else begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end
endmodule // opbr_reader
`default_nettype wire

// ---- opbr_reader_asserts.sv ----
// Port-level checks for the parameter fuse bank reader
`timescale 1ns/10ps
`default_nettype none
module opbr_reader_chk (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        PARAM_READY,
  input wire logic        NO_PARAMS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Bus answer timing and contents
  a_ready_next: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("ready without setup");
  a_data_idle: assert property (!PREADY |-> PRDATA == 32'h00000000) else $error("read data outside answer");
  a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_err_unmapped: assert property (PREADY && PADDR > 8'h28 |-> PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (PREADY && PADDR <= 8'h28 && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("mapped access refused");
  // Load status
  a_boot_load: assert property ($fell(RST) |-> ##[1:3] PARAM_READY) else $error("parameters not loaded");
  a_ready_sticks: assert property (PARAM_READY |=> PARAM_READY) else $error("ready flag dropped");
  a_none_loaded: assert property (NO_PARAMS |-> PARAM_READY) else $error("empty flag before load");
  // Main scenarios
  c_write: cover property (PREADY && PWRITE);
  c_refused: cover property (PSLVERR);
  c_empty: cover property ($rose(NO_PARAMS));
endmodule // opbr_reader_chk
bind opbr_reader opbr_reader_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PARAM_READY(PARAM_READY), .NO_PARAMS(NO_PARAMS));
`default_nettype wire

// ---- opbr_cpu_model.sv ----
// Processor-side bus master that reads and programs the parameter store
`timescale 1ns/10ps
`default_nettype none
module opbr_cpu_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer: setup, access until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule // opbr_cpu_model
`default_nettype wire

// ---- test_otp_param_bank_reader.sv ----
// Self-checking bench for the parameter fuse bank reader
`timescale 1ns/10ps
`default_nettype none
module test_otp_param_bank_reader;
  localparam logic [47:0] MAC = 48'h1234FFFFFFFF;
  localparam logic [14:0] XO  = 15'h1234;
  localparam logic [8:0]  IQG = 9'h0AB;
  localparam logic [8:0]  IQP = 9'h155;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, param_ready, no_params, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Clock and timeout
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  opbr_reader #(.PROG_CYCLES(16'h0004), .SHIP_MAC(MAC), .SHIP_XO(XO), .SHIP_IQG(IQG), .SHIP_IQP(IQP)) dut (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PARAM_READY(param_ready),
    .NO_PARAMS(no_params));
  opbr_cpu_model cpu (.clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Verdict
  task test_done;
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Word and flag comparisons
  task chk(input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  task chk_bit(input logic x, input logic g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // Register access and programming helpers
  task rd(input logic [7:0] a, input logic [31:0] x);
    cpu.xfer(1'b0, a, 32'h00000000, q, e);
    chk(x, q);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q, e);
  endtask
  task prog(input logic [2:0] b, input logic [1:0] w, input logic [31:0] d);
    wr(8'h08, {26'h0, w, 1'b0, b});
    wr(8'h0C, d);
    wr(8'h00, 32'h00000002);
    q = 32'h00000004;
    while (q[2] !== 1'b0) cpu.xfer(1'b0, 8'h04, 32'h00000000, q, e);
  endtask
  task reload;
    wr(8'h00, 32'h00000001);
    repeat (5) @(posedge ref_clk);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    while (param_ready !== 1'b1) @(posedge ref_clk);
    chk_bit(1'b1, param_ready);
    chk_bit(1'b0, no_params);
    rd(8'h04, 32'h00000131);
    rd(8'h14, MAC[31:0]);
    rd(8'h18, {16'h8000, MAC[47:32]});
    rd(8'h1C, 32'h00000000);
    rd(8'h20, 32'h80001235);
    rd(8'h24, {7'h00, XO, 1'b1, 1'b0, 8'h00});
    rd(8'h28, {12'h000, 1'b1, IQP, 1'b1, IQG});
    wr(8'h14, 32'h00000000);
    rd(8'h14, MAC[31:0]);
    rd(8'h00, 32'h00000000);
    rd(8'h30, 32'h00000000);
    chk_bit(1'b1, e);
    wr(8'h40, 32'hFFFFFFFF);
    chk_bit(1'b1, e);
    prog(3'h0, 2'h0, 32'h00000002);
    prog(3'h1, 2'h0, 32'h00000002);
    prog(3'h3, 2'h0, 32'h00000002);
    prog(3'h4, 2'h2, 32'h003FF000);
    prog(3'h4, 2'h0, 32'h00000001);
    reload();
    rd(8'h04, 32'h00000041);
    rd(8'h28, 32'h00000200);
    rd(8'h18, 32'h00000000);
    rd(8'h10, 32'h00000001);
    prog(3'h4, 2'h0, 32'h00000002);
    rd(8'h08, 32'h00000004);
    rd(8'h0C, 32'h00000002);
    reload();
    rd(8'h04, 32'h00000003);
    chk_bit(1'b1, no_params);
    wr(8'h08, 32'h0000003E);
    rd(8'h08, 32'h00000036);
    rd(8'h10, 32'h00000000);
    // Mid-run reset restores the shipped image
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_bit(1'b0, param_ready);
    while (param_ready !== 1'b1) @(posedge ref_clk);
    rd(8'h04, 32'h00000131);
    rd(8'h28, {12'h000, 1'b1, IQP, 1'b1, IQG});
    test_done();
  end
endmodule // test_otp_param_bank_reader
`default_nettype wire
